// *** rtl/pwd_pkg.sv ***
// Package: constants and carrier types for the PWM output and delay port block
package pwd_pkg;

  // Register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_LEVEL  = 8'h08;

  // Control register field positions
  localparam int CB_GPD    = 0;
  localparam int CB_AUX_ON = 1;
  localparam int CB_FMT    = 2;
  localparam int CB_DSEL   = 3;
  localparam int CB_THERM  = 5;
  localparam int CB_LPWM   = 6;
  localparam int CB_LAYOUT = 8;
  localparam int CB_RAMP   = 10;
  localparam int CB_PDOUT  = 12;

  // Field encodings
  localparam logic [1:0] DSEL_OFF        = 2'h0;
  localparam logic [1:0] DSEL_DELAY      = 2'h1;
  localparam logic [1:0] DSEL_WARN       = 2'h2;
  localparam logic [1:0] LAYOUT_FULL     = 2'h0;
  localparam logic [1:0] LAYOUT_HALF_SUB = 2'h1;
  localparam logic [1:0] LAYOUT_PARALLEL = 2'h2;
  localparam logic [1:0] RAMP_OFF        = 2'h3;

  // Values after reset
  localparam logic       RST_GPD   = 1'b1;
  localparam logic [1:0] RST_RAMP  = 2'h3;
  localparam logic [3:0] RST_PDOUT = 4'hF;

  // Serial frame layout
  localparam int         SAMPLE_W  = 24;
  localparam logic [4:0] LAST_SLOT = 5'h1F;
  localparam logic [4:0] I2S_LEAD  = 5'h01;
  localparam logic [4:0] LAST_BIT  = 5'h17;

  // Link bit clock timing
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned AUX_BCLK_NS    = 400;
  localparam logic [1:0]  AUX_HALF_LAST  = 2'(AUX_BCLK_NS / CLK_PERIOD_NS / 2 - 1);

  // Ramp to mid-supply bias, 255 level steps (levels 00 to FF) per full ramp
  localparam logic [7:0]  LVL_FULL     = 8'hFF;
  localparam int unsigned RAMP_STEPS   = 256;
  localparam int unsigned RAMP_MS_0    = 2160;
  localparam int unsigned RAMP_MS_1    = 2200;
  localparam int unsigned RAMP_MS_2    = 2200;
  localparam int unsigned CYC_PER_MS   = 1000000 / CLK_PERIOD_NS;
  localparam int unsigned RAMP_STEP_CYC_0 = RAMP_MS_0 * CYC_PER_MS / RAMP_STEPS;
  localparam int unsigned RAMP_STEP_CYC_1 = RAMP_MS_1 * CYC_PER_MS / RAMP_STEPS;
  localparam int unsigned RAMP_STEP_CYC_2 = RAMP_MS_2 * CYC_PER_MS / RAMP_STEPS;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pwd_reg_req_t;

  // Stereo sample pair
  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } pwd_stereo_t;

  // Returned delayed pair with one-cycle valid
  typedef struct packed {
    pwd_stereo_t data;
    logic        valid;
  } pwd_return_t;

  // Modulator bit streams
  typedef struct packed {
    logic ch1_p;
    logic ch1_m;
    logic ch2_p;
    logic ch2_m;
    logic sub_p;
    logic sub_m;
  } pwd_mod_t;

  // Whole state of the block
  typedef struct packed {
    logic                gpd;
    logic                aux_on;
    logic                fmt_lj;
    logic [1:0]          dsel;
    logic                therm_on;
    logic                lpwm_on;
    logic [1:0]          layout;
    logic [1:0]          ramp_sel;
    logic [3:0]          pdout;
    logic [31:0]         rdata;
    logic [1:0]          sync;
    logic [1:0]          div;
    logic                bclk;
    logic                fclk;
    logic                half;
    logic [4:0]          slot;
    logic [31:0]         tx_sh;
    logic [SAMPLE_W-1:0] rx_sh;
    logic [SAMPLE_W-1:0] rx_left;
    pwd_return_t         ret;
    logic [31:0]         ramp_cnt;
    logic                ramp_tick;
    logic [7:0]          pwm_cnt;
    logic [3:0][7:0]     lvl;
    logic [3:0]          pins;
    logic                dout;
    logic                dout_oe;
    logic                aux_dout;
    logic [1:0]          lpwm;
    logic                lpwm_oe;
    logic                warn;
  } pwd_state_t;

  localparam pwd_state_t ST_RESET = '{gpd: RST_GPD, ramp_sel: RST_RAMP, pdout: RST_PDOUT,
                                      default: '0};

endpackage

// *** rtl/pwd_top.sv ***
// PWM output mapping, pop ramp, logic PWM drivers and delay/warning port
//
// Overview of operation
// - Delay mode sends selected source samples out, returns delayed ones inward
// - Delay link uses the aux frame and bit clocks only
// - Aux format select sets I2S or left-justified for both directions
// - Warning mode: shared input is active-low warning, delay output floats
// - External warning reaches foldback only while thermal foldback is on
// - Layout 00: two full bridges, ch1 on pins a/b, ch2 on c/d
// - Layout 01: ch1 half on a, ch2 half on b, sub full on c/d
// - Layout 10: ch1 plus on a and b, ch1 minus on c and d
// - Layout field writes count only while global power-down is set
// - Ramp enabled: powered outputs ramp linearly to and from mid bias
// - Logic PWM outputs and aux output are never ramped
// - Ramp active for any rate value except 11, which is instant
// - One ramp rate applies to all powered outputs together
// - Logic PWM outputs float until their drive enable is set
// - Logic PWM outputs skip the powered outputs' click-free ramp; held low in power-down
// - Port select chooses delay, warning or off; off floats both pins
// - Aux port on drives its clocks; off holds clocks and data low
module pwd_top #(
  parameter int unsigned RAMP_STEP_CYC_0 = pwd_pkg::RAMP_STEP_CYC_0,
  parameter int unsigned RAMP_STEP_CYC_1 = pwd_pkg::RAMP_STEP_CYC_1,
  parameter int unsigned RAMP_STEP_CYC_2 = pwd_pkg::RAMP_STEP_CYC_2
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  // Register port
  input  wire pwd_pkg::pwd_reg_req_t reg_req,
  output logic [31:0]                reg_rdata,
  // Audio streams
  input  wire pwd_pkg::pwd_stereo_t  src_samples,
  output pwd_pkg::pwd_return_t       dly_return,
  input  wire pwd_pkg::pwd_mod_t     mod_in,
  input  wire logic [1:0]            logic_src,
  output logic                       thermal_warning_out,
  // Delay and warning port pins
  output logic                       delay_serial_out,
  output logic                       delay_serial_out_oe,
  input  wire logic                  delay_in_or_warning,
  // Aux port pins
  output logic                       aux_frame_clock,
  output logic                       aux_bit_clock,
  output logic                       aux_serial_out,
  // Powered outputs
  output logic                       power_pin_a,
  output logic                       power_pin_b,
  output logic                       power_pin_c,
  output logic                       power_pin_d,
  // Logic-level PWM outputs
  output logic                       logic_pwm_first,
  output logic                       logic_pwm_first_oe,
  output logic                       logic_pwm_second,
  output logic                       logic_pwm_second_oe
);
  import pwd_pkg::*;

  pwd_state_t  st;
  pwd_state_t  next_st;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [3:0]  ramp_done;

  // Read-back images of control and status
  assign ctrl_word = {16'h0000, st.pdout, st.ramp_sel, st.layout, 1'b0, st.lpwm_on,
                      st.therm_on, st.dsel, st.fmt_lj, st.aux_on, st.gpd};
  assign status_word = {24'h00_0000, ramp_done, 2'b00, st.warn, ~st.sync[1]};

  // Per-output ramp completion flags
  for (genvar g = 0; g < 4; g++) begin : g_done
    assign ramp_done[g] = (st.lvl[g] == LVL_FULL);
  end

  // Next-state logic for the whole block
  always_comb begin
    logic                rise;
    logic                fall;
    logic [4:0]          start;
    logic [4:0]          idx;
    logic [SAMPLE_W-1:0] rx_word;
    logic [31:0]         step;
    logic [3:0]          map;
    logic                powered;
    rise    = 1'b0;
    fall    = 1'b0;
    start   = '0;
    idx     = '0;
    rx_word = '0;
    step    = '0;
    map     = '0;
    powered = 1'b0;
    next_st = st;

    // Pin synchroniser; only the second stage is read below
    next_st.sync = {st.sync[0], delay_in_or_warning};

    // Register writes
    if (reg_req.wr) begin
      if (reg_req.addr == OFS_CTRL) begin
        next_st.gpd      = reg_req.wdata[CB_GPD];
        next_st.aux_on   = reg_req.wdata[CB_AUX_ON];
        next_st.fmt_lj   = reg_req.wdata[CB_FMT];
        next_st.dsel     = reg_req.wdata[CB_DSEL +: 2];
        next_st.therm_on = reg_req.wdata[CB_THERM];
        next_st.lpwm_on  = reg_req.wdata[CB_LPWM];
        next_st.ramp_sel = reg_req.wdata[CB_RAMP +: 2];
        next_st.pdout    = reg_req.wdata[CB_PDOUT +: 4];
        // Mapping may only move while modulators are stopped
        if (st.gpd) begin
          next_st.layout = reg_req.wdata[CB_LAYOUT +: 2];
        end
      end
    end

    // Register reads: data stand only in the cycle after the strobe
    next_st.rdata = '0;
    if (reg_req.rd) begin
      if (reg_req.addr == OFS_CTRL) begin
        next_st.rdata = ctrl_word;
      end else if (reg_req.addr == OFS_STATUS) begin
        next_st.rdata = status_word;
      end else if (reg_req.addr == OFS_LEVEL) begin
        next_st.rdata = st.lvl;
      end
    end

    // Aux clock master; the delay link rides on these same clocks
    if (!st.aux_on) begin
      next_st.div   = '0;
      next_st.bclk  = 1'b0;
      next_st.fclk  = 1'b0;
      next_st.half  = 1'b0;
      next_st.slot  = '0;
      next_st.tx_sh = '0;
    end else if (st.div == AUX_HALF_LAST) begin
      next_st.div  = '0;
      next_st.bclk = ~st.bclk;
      rise         = ~st.bclk;
      fall         = st.bclk;
    end else begin
      next_st.div = st.div + 2'h1;
    end

    // I2S leads data by one bit after the frame edge, left-justified does not
    start = st.fmt_lj ? 5'h00 : I2S_LEAD;
    idx   = 5'(st.slot - start);

    // Transmit on falling bit clock, MSB first
    if (fall) begin
      next_st.slot = st.slot + 5'h01;
      if (st.slot == LAST_SLOT) begin
        next_st.half = ~st.half;
      end
      // I2S: left while frame low; left-justified: left while frame high
      next_st.fclk = next_st.half ^ st.fmt_lj;
      if (next_st.slot == start) begin
        next_st.tx_sh = {next_st.half ? src_samples.right : src_samples.left, 8'h00};
      end else begin
        next_st.tx_sh = st.tx_sh << 1;
      end
    end

    // Receive on rising bit clock; a pair is handed inward after the right word
    next_st.ret.valid = 1'b0;
    if (rise && idx <= LAST_BIT) begin
      rx_word       = {st.rx_sh[SAMPLE_W-2:0], st.sync[1]};
      next_st.rx_sh = rx_word;
      if (idx == LAST_BIT) begin
        if (!st.half) begin
          next_st.rx_left = rx_word;
        end else if (st.dsel == DSEL_DELAY) begin
          next_st.ret.data  = '{left: st.rx_left, right: rx_word};
          next_st.ret.valid = 1'b1;
        end
      end
    end

    // Delay/warning pins; anything but delay mode floats the output
    next_st.dout_oe  = (st.dsel == DSEL_DELAY);
    next_st.dout     = (st.dsel == DSEL_DELAY) && st.aux_on && st.tx_sh[31];
    next_st.aux_dout = st.aux_on && st.tx_sh[31];
    // Warning is active low and only reaches foldback when enabled
    next_st.warn = (st.dsel == DSEL_WARN) && st.therm_on && !st.sync[1];

    // One shared step timer sets the rate for every output
    case (st.ramp_sel)
      2'h1:    step = RAMP_STEP_CYC_1;
      2'h2:    step = RAMP_STEP_CYC_2;
      default: step = RAMP_STEP_CYC_0;
    endcase
    next_st.ramp_tick = 1'b0;
    if (st.ramp_cnt + 32'h0000_0001 >= step) begin
      next_st.ramp_cnt  = '0;
      next_st.ramp_tick = 1'b1;
    end else begin
      next_st.ramp_cnt = st.ramp_cnt + 32'h0000_0001;
    end
    next_st.pwm_cnt = st.pwm_cnt + 8'h01;

    // Pin mapping; reserved layout falls back to two full bridges
    case (st.layout)
      LAYOUT_HALF_SUB: map = {mod_in.sub_m, mod_in.sub_p, mod_in.ch2_p, mod_in.ch1_p};
      LAYOUT_PARALLEL: map = {mod_in.ch1_m, mod_in.ch1_m, mod_in.ch1_p, mod_in.ch1_p};
      default:         map = {mod_in.ch2_m, mod_in.ch2_p, mod_in.ch1_m, mod_in.ch1_p};
    endcase

    // Ramp each powered output; below full level the pin carries a bias PWM
    // whose duty tracks the level, so it tops out at half duty (mid supply)
    for (int i = 0; i < 4; i++) begin
      powered = !st.gpd && !st.pdout[i];
      if (st.ramp_sel == RAMP_OFF) begin
        next_st.lvl[i] = powered ? LVL_FULL : 8'h00;
      end else if (st.ramp_tick) begin
        if (powered && st.lvl[i] != LVL_FULL) begin
          next_st.lvl[i] = st.lvl[i] + 8'h01;
        end else if (!powered && st.lvl[i] != 8'h00) begin
          next_st.lvl[i] = st.lvl[i] - 8'h01;
        end
      end
      if (powered && st.lvl[i] == LVL_FULL) begin
        next_st.pins[i] = map[i];
      end else begin
        next_st.pins[i] = (st.pwm_cnt < {1'b0, st.lvl[i][7:1]});
      end
    end

    // Logic PWM: no ramp, held low while modulators are stopped, like the
    // powered pins at instant start; drivers float until enabled
    next_st.lpwm    = st.gpd ? 2'b00 : logic_src;
    next_st.lpwm_oe = st.lpwm_on;
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from state flops
  assign reg_rdata           = st.rdata;
  assign dly_return          = st.ret;
  assign thermal_warning_out = st.warn;
  assign delay_serial_out    = st.dout;
  assign delay_serial_out_oe = st.dout_oe;
  assign aux_frame_clock     = st.fclk;
  assign aux_bit_clock       = st.bclk;
  assign aux_serial_out      = st.aux_dout;
  assign power_pin_a         = st.pins[0];
  assign power_pin_b         = st.pins[1];
  assign power_pin_c         = st.pins[2];
  assign power_pin_d         = st.pins[3];
  assign logic_pwm_first     = st.lpwm[0];
  assign logic_pwm_second    = st.lpwm[1];
  assign logic_pwm_first_oe  = st.lpwm_oe;
  assign logic_pwm_second_oe = st.lpwm_oe;

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_DELAY_DRIVE: assert property (st.dsel == DSEL_DELAY |=> delay_serial_out_oe)
    else $error("Delay output not driven in delay mode");
  AST_WARN_FLOAT: assert property (st.dsel == DSEL_WARN |=> !delay_serial_out_oe)
    else $error("Delay output driven in warning mode");
  AST_OFF_FLOAT: assert property ((st.dsel != DSEL_DELAY && st.dsel != DSEL_WARN)
    |=> !delay_serial_out_oe && !delay_serial_out)
    else $error("Delay port not floating while off");
  AST_WARN_GATE: assert property (thermal_warning_out
    |-> $past(st.therm_on) && $past(st.dsel) == DSEL_WARN)
    else $error("Warning passed without foldback enabled");
  AST_AUX_QUIET: assert property (!st.aux_on [*2]
    |=> !aux_bit_clock && !aux_frame_clock && !aux_serial_out)
    else $error("Aux pins not low while port off");
  AST_BCLK_HALF: assert property ($rose(aux_bit_clock)
    |-> ##1 (aux_bit_clock || !st.aux_on) [*3])
    else $error("Bit clock high phase too short");
  AST_LAYOUT_LOCK: assert property (reg_req.wr && reg_req.addr == OFS_CTRL && !st.gpd
    |=> $stable(st.layout))
    else $error("Layout changed while powered up");
  AST_RAMP_INSTANT: assert property (st.ramp_sel == RAMP_OFF && !st.gpd && !st.pdout[0]
    |=> st.lvl[0] == LVL_FULL)
    else $error("Output not at full level with ramp off");
  AST_RAMP_PACE: assert property (st.ramp_sel != RAMP_OFF && !st.ramp_tick
    |=> $stable(st.lvl))
    else $error("Level moved between ramp steps");
  AST_MAP_FULL: assert property (st.layout == LAYOUT_FULL && ramp_done[3] && !st.gpd
    && !st.pdout[3] |=> power_pin_d == $past(mod_in.ch2_m))
    else $error("Full-bridge mapping wrong on pin d");
  AST_MAP_HALF: assert property (st.layout == LAYOUT_HALF_SUB && ramp_done[2] && !st.gpd
    && !st.pdout[2] |=> power_pin_c == $past(mod_in.sub_p))
    else $error("Sub mapping wrong on pin c");
  AST_MAP_PAR: assert property (st.layout == LAYOUT_PARALLEL && ramp_done[1] && !st.gpd
    && !st.pdout[1] |=> power_pin_b == $past(mod_in.ch1_p))
    else $error("Parallel mapping wrong on pin b");
  AST_LPWM_FLOAT: assert property (!st.lpwm_on
    |=> !logic_pwm_first_oe && !logic_pwm_second_oe)
    else $error("Logic PWM driven while disabled");
  AST_LPWM_QUIET: assert property (st.gpd |=> !logic_pwm_first && !logic_pwm_second)
    else $error("Logic PWM active during power-down");

  COV_RETURN: cover property (dly_return.valid);
  COV_WARN: cover property ($rose(thermal_warning_out));
  COV_RAMP_UP: cover property ($rose(ramp_done[0]) && st.ramp_sel != RAMP_OFF);
endmodule

// *** verification/pwd_delay_model.sv ***
// Partner model: external serial delay chip or external warning source on the delay port
module pwd_delay_model (
  // Link from the block
  input  wire logic aux_bit_clock,
  input  wire logic delay_serial_out,
  // Bench control
  input  wire logic warn_mode,
  input  wire logic warn_n,
  // Return pin
  output logic      delay_in_or_warning
);
  timeunit 1ns;
  timeprecision 1ns;
  // Known start so the return pin never floats to an unknown
  logic [63:0] hist    = '0;
  logic        ret_bit = 1'b0;

  // Capture on the rising bit clock; only the block's clocks pace the link
  always @(posedge aux_bit_clock) begin
    hist <= {hist[62:0], delay_serial_out};
  end

  // One whole frame of delay keeps every slot, so the format comes back unchanged
  always @(negedge aux_bit_clock) begin
    ret_bit <= hist[63];
  end

  // Warning mode drives the active-low level instead of data
  assign delay_in_or_warning = warn_mode ? warn_n : ret_bit;
endmodule

// *** verification/tb_top.sv ***
// Testbench for the PWM output mapping, pop ramp, logic PWM and delay/warning port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pwd_pkg::*;
  localparam int unsigned STEPS [3] = '{2, 3, 4};
  logic         core_clk;
  logic         rst_n;
  pwd_reg_req_t reg_req;
  logic [31:0]  reg_rdata;
  pwd_stereo_t  src_samples;
  pwd_return_t  dly_return;
  pwd_mod_t     mod_in;
  logic [1:0]   logic_src;
  logic         thermal_warning_out;
  logic         delay_serial_out;
  logic         delay_serial_out_oe;
  logic         delay_in_or_warning;
  logic         aux_frame_clock;
  logic         aux_bit_clock;
  logic         aux_serial_out;
  logic [3:0]   pins;
  logic [3:0]   lpwm;
  logic         warn_mode;
  logic         warn_n;
  logic [31:0]  rv;
  logic [1:0]   fb;
  int           num_errors;
  int           tests_run;
  int           n;

  // Shortened ramp steps keep the run brief
  pwd_top #(.RAMP_STEP_CYC_0(STEPS[0]), .RAMP_STEP_CYC_1(STEPS[1]), .RAMP_STEP_CYC_2(STEPS[2]))
  dut (.core_clk(core_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .src_samples(src_samples), .dly_return(dly_return), .mod_in(mod_in),
    .logic_src(logic_src), .thermal_warning_out(thermal_warning_out),
    .delay_serial_out(delay_serial_out), .delay_serial_out_oe(delay_serial_out_oe),
    .delay_in_or_warning(delay_in_or_warning), .aux_frame_clock(aux_frame_clock),
    .aux_bit_clock(aux_bit_clock), .aux_serial_out(aux_serial_out),
    .power_pin_a(pins[0]), .power_pin_b(pins[1]), .power_pin_c(pins[2]),
    .power_pin_d(pins[3]), .logic_pwm_first(lpwm[0]), .logic_pwm_first_oe(lpwm[1]),
    .logic_pwm_second(lpwm[2]), .logic_pwm_second_oe(lpwm[3]));

  pwd_delay_model partner (.aux_bit_clock(aux_bit_clock), .delay_serial_out(delay_serial_out),
    .warn_mode(warn_mode), .warn_n(warn_n), .delay_in_or_warning(delay_in_or_warning));

  // 20 MHz core clock
  initial core_clk = 1'b0;
  always #25 core_clk = ~core_clk;

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bus cycles; each ends one edge after dropping its strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge core_clk);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Poll a register until the masked value appears, counting core cycles
  task automatic poll(input logic [7:0] a, input logic [31:0] m, v, output int k);
    k = 0;
    do begin
      rd(a, rv);
      k += 2;
      if (k > 3000) begin
        num_errors++;
        results();
      end
    end while ((rv & m) !== v);
  endtask

  function automatic logic sig(input int w);
    return (w == 0) ? aux_bit_clock : (w == 1) ? aux_frame_clock : dly_return.valid;
  endfunction

  // Wait for a rising (lvl 1) or falling (lvl 0) change, counting core cycles
  task automatic wait_sig(input int w, input logic lvl, output int k);
    logic prev;
    logic cur;
    k = 0;
    cur = sig(w);
    do begin
      prev = cur;
      @(posedge core_clk);
      #1 cur = sig(w);
      k++;
      if (k > 2000) begin
        num_errors++;
        results();
      end
    end while (!(prev !== lvl && cur === lvl));
  endtask

  function automatic logic [31:0] ctrl(logic g, a, f, logic [1:0] ds, logic th, lp,
                                       logic [1:0] lay, rmp);
    return {20'h0_0000, rmp, lay, 1'b0, lp, th, ds, f, a, g};
  endfunction

  // Expected pins {d, c, b, a}; reserved layout falls back to two full bridges
  function automatic logic [3:0] map(logic [1:0] lay, pwd_mod_t m);
    case (lay)
      LAYOUT_HALF_SUB: return {m.sub_m, m.sub_p, m.ch2_p, m.ch1_p};
      LAYOUT_PARALLEL: return {m.ch1_m, m.ch1_m, m.ch1_p, m.ch1_p};
      default:         return {m.ch2_m, m.ch2_p, m.ch1_m, m.ch1_p};
    endcase
  endfunction

  initial begin
    rst_n = 1'b0;
    reg_req = '0;
    src_samples = '{left: 24'h80_0001, right: 24'hC3_5A5A};
    mod_in = '0;
    logic_src = 2'h0;
    warn_mode = 1'b0;
    warn_n = 1'b1;
    num_errors = 0;
    tests_run = 0;
    cyc(16);
    rst_n <= 1'b1;
    @(posedge core_clk);
    // Reset values, floating pins and an unmapped read
    check(64'({lpwm[1], lpwm[3], delay_serial_out_oe, aux_bit_clock}), 0);
    rd(OFS_CTRL, rv);
    check(64'(rv), 64'h0000_0000_0000_FC01);
    rd(8'h0C, rv);
    check(64'(rv), 0);
    // Layout writes while powered up are dropped, other fields still land
    wr(OFS_CTRL, ctrl(1, 0, 0, DSEL_OFF, 0, 0, LAYOUT_PARALLEL, RAMP_OFF));
    wr(OFS_CTRL, ctrl(0, 0, 0, DSEL_OFF, 0, 0, LAYOUT_PARALLEL, RAMP_OFF));
    wr(OFS_CTRL, ctrl(0, 0, 0, DSEL_OFF, 0, 1, LAYOUT_HALF_SUB, RAMP_OFF));
    rd(OFS_CTRL, rv);
    check(64'(rv), 64'(ctrl(0, 0, 0, DSEL_OFF, 0, 1, LAYOUT_PARALLEL, RAMP_OFF)));
    // Every layout code against a spread of modulator patterns
    for (int l = 0; l < 4; l++) begin
      wr(OFS_CTRL, ctrl(1, 0, 0, DSEL_OFF, 0, 0, 2'(l), RAMP_OFF));
      wr(OFS_CTRL, ctrl(0, 0, 0, DSEL_OFF, 0, 0, 2'(l), RAMP_OFF));
      for (int k = 0; k < 64; k += 7) begin
        mod_in <= 6'(k);
        cyc(4);
        check(64'(pins), 64'(map(2'(l), 6'(k))));
      end
    end
    // Logic PWM drivers stay off until enabled and stay low in power-down
    check(64'({lpwm[1], lpwm[3]}), 0);
    logic_src <= 2'h2;
    wr(OFS_CTRL, ctrl(0, 0, 0, DSEL_OFF, 0, 1, LAYOUT_FULL, RAMP_OFF));
    cyc(2);
    check(64'(lpwm), 64'h0000_0000_0000_000E);
    wr(OFS_CTRL, ctrl(1, 0, 0, DSEL_OFF, 0, 1, LAYOUT_FULL, RAMP_OFF));
    cyc(2);
    check(64'(lpwm), 64'h0000_0000_0000_000A);
    // Each ramp rate: all pins together up and down; logic PWM is not ramped
    logic_src <= 2'h3;
    for (int r = 0; r < 3; r++) begin
      wr(OFS_CTRL, ctrl(1, 0, 0, DSEL_OFF, 0, 1, LAYOUT_HALF_SUB, 2'(r)));
      wr(OFS_CTRL, ctrl(0, 0, 0, DSEL_OFF, 0, 1, LAYOUT_HALF_SUB, 2'(r)));
      cyc(1);
      check(64'({lpwm[0], lpwm[2]}), 64'h0000_0000_0000_0003);
      rd(OFS_LEVEL, rv);
      check(64'({rv == {4{rv[7:0]}}, rv[7:0] < 8'h10}), 64'h0000_0000_0000_0003);
      poll(OFS_STATUS, 32'h0000_00F0, 32'h0000_00F0, n);
      check(64'(n >= 250 * STEPS[r] && n <= 256 * STEPS[r] + 16), 1);
      if (r == 0) begin
        wr(OFS_CTRL, ctrl(0, 0, 0, DSEL_OFF, 0, 1, LAYOUT_HALF_SUB, 2'(r)) | 32'h0000_1000);
        cyc(40);
        rd(OFS_LEVEL, rv);
        check(64'(rv[31:8] == 24'hFF_FFFF && rv[7:0] < 8'hFF), 1);
      end
      wr(OFS_CTRL, ctrl(1, 0, 0, DSEL_OFF, 0, 1, LAYOUT_HALF_SUB, 2'(r)));
      poll(OFS_LEVEL, 32'hFFFF_FFFF, 32'h0000_0000, n);
      check(64'(n >= 250 * STEPS[r] && n <= 256 * STEPS[r] + 16), 1);
    end
    // Delay link in both formats; aux port is switched on in the same write as delay mode
    for (int f = 0; f < 2; f++) begin
      wr(OFS_CTRL, ctrl(0, 1, 1'(f), DSEL_DELAY, 0, 0, LAYOUT_FULL, RAMP_OFF));
      cyc(2);
      check(64'(delay_serial_out_oe), 1);
      wait_sig(0, 1, n);
      wait_sig(0, 1, n);
      check(64'(n), 8);
      wait_sig(1, 1'(f), n);
      wait_sig(0, 1, n);
      fb[1] = delay_serial_out;
      wait_sig(0, 1, n);
      fb[0] = delay_serial_out;
      check(64'(aux_serial_out), 64'(f == 0));
      check(64'(fb), (f == 0) ? 64'h0000_0000_0000_0001 : 64'h0000_0000_0000_0002);
      repeat (3) wait_sig(2, 1, n);
      check(64'(dly_return.data), 64'(src_samples));
    end
    // Aux port off: clocks and data held low, nothing returns
    wr(OFS_CTRL, ctrl(0, 0, 0, DSEL_DELAY, 0, 0, LAYOUT_FULL, RAMP_OFF));
    cyc(4);
    fb = 2'h0;
    repeat (600) begin
      @(posedge core_clk);
      #1 fb[0] = fb[0] | aux_bit_clock | aux_frame_clock | aux_serial_out | delay_serial_out;
      fb[1] = fb[1] | dly_return.valid;
    end
    check(64'(fb), 0);
    // Warning mode: active-low input, gated by foldback enable, data pin floats
    warn_mode <= 1'b1;
    warn_n <= 1'b0;
    wr(OFS_CTRL, ctrl(0, 1, 0, DSEL_WARN, 0, 0, LAYOUT_FULL, RAMP_OFF));
    cyc(6);
    check(64'({delay_serial_out_oe, thermal_warning_out}), 0);
    rd(OFS_STATUS, rv);
    check(64'(rv[0]), 1);
    wr(OFS_CTRL, ctrl(0, 1, 0, DSEL_WARN, 1, 0, LAYOUT_FULL, RAMP_OFF));
    cyc(6);
    check(64'(thermal_warning_out), 1);
    rd(OFS_STATUS, rv);
    check(64'(rv[1:0]), 3);
    warn_n <= 1'b1;
    cyc(6);
    check(64'(thermal_warning_out), 0);
    warn_n <= 1'b0;
    wr(OFS_CTRL, ctrl(0, 1, 0, DSEL_OFF, 1, 0, LAYOUT_FULL, RAMP_OFF));
    cyc(6);
    check(64'({delay_serial_out_oe, thermal_warning_out}), 0);
    // Spare select code also means off, even with the warning pin active
    wr(OFS_CTRL, ctrl(0, 1, 0, 2'h3, 1, 0, LAYOUT_FULL, RAMP_OFF));
    cyc(6);
    check(64'({delay_serial_out_oe, thermal_warning_out}), 0);
    results();
  end
endmodule
